//--- rtl/bsd_pkg.sv
package bsd_pkg;

	// ============================================================
	// Reset values and fixed addresses
	localparam logic [15:0] BSD_RESET_PC = 16'h0100;
	localparam logic [15:0] BSD_TRAP_VEC_BASE = 16'h0020;
	localparam logic [15:0] BSD_PC_STEP = 16'h0002;
	localparam logic [7:0] BSD_CCR_RESET = 8'h80;
	localparam logic [7:0] BSD_EXR_RESET = 8'h07;

	// ============================================================
	// Flag positions within the condition-code register
	localparam int BSD_FLAG_C = 0;
	localparam int BSD_FLAG_V = 1;
	localparam int BSD_FLAG_Z = 2;
	localparam int BSD_FLAG_N = 3;

	// ============================================================
	// Operation field codes (bits 15:12 of the first word)
	localparam logic [3:0] BSD_OP_SYS = 4'h0;
	localparam logic [3:0] BSD_OP_CTL = 4'h1;
	localparam logic [3:0] BSD_OP_BCC = 4'h4;
	localparam logic [3:0] BSD_OP_JUMP = 4'h5;
	localparam logic [3:0] BSD_OP_MOVE = 4'h7;

	// System group second operation field
	localparam logic [3:0] BSD_SYS_NOP = 4'h0;
	localparam logic [3:0] BSD_SYS_SLEEP = 4'h1;
	localparam logic [3:0] BSD_SYS_RTE = 4'h2;
	localparam logic [3:0] BSD_SYS_TRAP = 4'h3;
	localparam logic [3:0] BSD_SYS_RTS = 4'h4;

	// Jump group second operation field
	localparam logic [3:0] BSD_JMP_ABS = 4'h0;
	localparam logic [3:0] BSD_JMP_SUB = 4'h1;
	localparam logic [3:0] BSD_JMP_BSR = 4'h2;

	// Control-register group function (bits 10:8), bit 11 selects the extended register
	localparam logic [2:0] BSD_CTL_AND = 3'h0;
	localparam logic [2:0] BSD_CTL_OR = 3'h1;
	localparam logic [2:0] BSD_CTL_XOR = 3'h2;
	localparam logic [2:0] BSD_CTL_LDI = 3'h3;
	localparam logic [2:0] BSD_CTL_LDM = 3'h4;
	localparam logic [2:0] BSD_CTL_STM = 3'h5;

	// ============================================================
	// Register map of the software port
	localparam logic [7:0] BSD_REG_CTRL = 8'h00;
	localparam logic [7:0] BSD_REG_STATUS = 8'h04;
	localparam logic [7:0] BSD_REG_PC = 8'h08;
	localparam logic [7:0] BSD_REG_CCR = 8'h0c;
	localparam logic [7:0] BSD_REG_EXR = 8'h10;
	localparam logic [7:0] BSD_REG_COUNT = 8'h14;
	localparam logic [7:0] BSD_REG_SRC = 8'h18;
	localparam logic [7:0] BSD_REG_DST = 8'h1c;

	// ============================================================
	// Sequencer states
	typedef enum logic [8:0] {
		ST_HALT = 9'h001,
		ST_FETCH = 9'h002,
		ST_EXT = 9'h004,
		ST_EXEC = 9'h008,
		ST_MEM = 9'h010,
		ST_MV_RD = 9'h020,
		ST_MV_WR = 9'h040,
		ST_VEC = 9'h080,
		ST_SLEEP = 9'h100
	} bsd_state_e;

	// Extension sizes: 8, 16 or 32 bits
	localparam logic [1:0] BSD_EXT_8 = 2'h0;
	localparam logic [1:0] BSD_EXT_16 = 2'h1;
	localparam logic [1:0] BSD_EXT_32 = 2'h2;

	// Widen an address extension; a 24-bit value carries a zero top byte
	function automatic logic [31:0] bsd_ea_extend(input logic [1:0] size, input logic [31:0] raw);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (size)
			BSD_EXT_8: r = {{24{raw[7]}}, raw[7:0]};
			BSD_EXT_16: r = {{16{raw[15]}}, raw[15:0]};
			default: r = {8'h00, raw[23:0]};
		endcase
		return r;
	endfunction

endpackage

//--- rtl/bsd_decode.sv
`timescale 1ns/1ps

// ============================================================
// Field extraction of the first instruction word
module bsd_decode import bsd_pkg::*; (
	input wire logic [15:0] instr,
	output logic [3:0] op,
	output logic [3:0] op2,
	output logic [3:0] cc,
	output logic [7:0] imm8,
	output logic [1:0] trap_vec,
	output logic [2:0] rn,
	output logic [3:0] rd,
	output logic needs_ext,
	output logic ext_long
);
	always_comb begin
		op = instr[15:12];
		op2 = instr[11:8];
		cc = instr[11:8];
		imm8 = instr[7:0];
		trap_vec = instr[5:4];
		rn = instr[6:4];
		// Byte-size operands address 8 registers, wider ones 16
		rd = instr[3] ? {1'b0, instr[2:0]} : instr[7:4];
		needs_ext = (op == BSD_OP_JUMP) ||
			((op == BSD_OP_CTL) && (instr[10:8] == BSD_CTL_LDM || instr[10:8] == BSD_CTL_STM));
		ext_long = instr[4];
	end
endmodule

//--- rtl/bsd_cond.sv
`timescale 1ns/1ps

// ============================================================
// Branch condition evaluation
module bsd_cond import bsd_pkg::*; (
	input wire logic [3:0] cc,
	input wire logic [7:0] ccr,
	output logic taken
);
	logic c;
	logic v;
	logic z;
	logic n;
	always_comb begin
		c = ccr[BSD_FLAG_C];
		v = ccr[BSD_FLAG_V];
		z = ccr[BSD_FLAG_Z];
		n = ccr[BSD_FLAG_N];
		unique case (cc)
			4'h0: taken = 1'b1;
			4'h1: taken = 1'b0;
			4'h2: taken = (c | z) == 1'b0;
			4'h3: taken = (c | z) == 1'b1;
			4'h4: taken = !c;
			4'h5: taken = c;
			4'h6: taken = !z;
			4'h7: taken = z;
			4'h8: taken = !v;
			4'h9: taken = v;
			4'ha: taken = !n;
			4'hb: taken = n;
			4'hc: taken = (n ^ v) == 1'b0;
			4'hd: taken = (n ^ v) == 1'b1;
			4'he: taken = (z | (n ^ v)) == 1'b0;
			4'hf: taken = (z | (n ^ v)) == 1'b1;
		endcase
	end
endmodule

//--- rtl/bsd_core.sv
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps

// Contract
// - Branch loads target only when condition true
// - Unsigned and single-flag branch conditions supported
// - Trap vector picked by immediate field
// - Exception return restores interrupted state
// - Sleep enters low power, stops fetching
// - Control register load reads whole word
// - Control register store writes whole word
// - AND, OR, XOR control register with immediate
// - No-operation only advances PC by two
// - Block move copies bytes, post-increments pointers
// - Counter decrements per byte; zero moves nothing
// - Next instruction only after move completes
// - Instructions built from 16-bit words
// - Operation field in first four bits
// - Address register field three bits wide
// - Data register field three or four bits
// - Extension 8, 16 or 32 bits
// - Condition field selects branch condition
module bsd_core import bsd_pkg::*; (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic mem_req,
	output logic mem_we,
	output logic mem_word,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ack,
	input wire logic wake_pin,
	output logic sleeping,
	output logic [3:0] dec_op2,
	output logic [2:0] dec_rn,
	output logic [3:0] dec_rd
);
	bsd_state_e state_q, state_d;
	logic [15:0] pc_q, pc_d;
	logic [15:0] ir_q, ir_d;
	logic [31:0] ext_q, ext_d;
	logic ext_more_q, ext_more_d;
	logic [7:0] ccr_q, ccr_d;
	logic [7:0] exr_q, exr_d;
	logic [15:0] count_q, count_d;
	logic [15:0] src_q, src_d;
	logic [15:0] dst_q, dst_d;
	logic [15:0] link_q, link_d;
	logic [15:0] save_pc_q, save_pc_d;
	logic [7:0] save_ccr_q, save_ccr_d;
	logic [7:0] save_exr_q, save_exr_d;
	logic [7:0] mv_byte_q, mv_byte_d;
	logic move_word_q, move_word_d;
	logic run_q, run_d;
	logic illegal_q, illegal_d;
	logic [15:0] rdata_q, rdata_d;
	logic [3:0] op2_q, op2_d;
	logic [2:0] rn_q, rn_d;
	logic [3:0] rd_q, rd_d;
	logic wake_meta_q;
	logic wake_sync_q;

	logic [3:0] f_op;
	logic [3:0] f_op2;
	logic [3:0] f_cc;
	logic [7:0] f_imm;
	logic [1:0] f_vec;
	logic [2:0] f_rn;
	logic [3:0] f_rd;
	logic f_ext;
	logic f_long;
	logic taken;
	logic [15:0] ea;
	logic [15:0] disp8;
	logic [7:0] ctl_val;
	logic [7:0] ctl_res;
	logic count_zero;
	logic [15:0] count_dec;

	// ============================================================
	// Decode and condition
	bsd_decode u_decode (
		.instr(ir_q),
		.op(f_op),
		.op2(f_op2),
		.cc(f_cc),
		.imm8(f_imm),
		.trap_vec(f_vec),
		.rn(f_rn),
		.rd(f_rd),
		.needs_ext(f_ext),
		.ext_long(f_long)
	);

	bsd_cond u_cond (
		.cc(f_cc),
		.ccr(ccr_q),
		.taken(taken)
	);

	// ============================================================
	// Memory port, driven from state and held registers
	always_comb begin
		mem_req = 1'b0;
		mem_we = 1'b0;
		mem_word = 1'b1;
		mem_addr = pc_q;
		mem_wdata = 16'h0000;
		unique case (state_q)
			ST_FETCH: mem_req = run_q;
			ST_EXT: mem_req = 1'b1;
			ST_MEM: begin
				mem_req = 1'b1;
				mem_addr = ea;
				mem_we = (f_op2[2:0] == BSD_CTL_STM);
				mem_wdata = {ctl_val, 8'h00};
			end
			ST_MV_RD: begin
				mem_req = 1'b1;
				mem_word = 1'b0;
				mem_addr = src_q;
			end
			ST_MV_WR: begin
				mem_req = 1'b1;
				mem_word = 1'b0;
				mem_we = 1'b1;
				mem_addr = dst_q;
				mem_wdata = {8'h00, mv_byte_q};
			end
			ST_VEC: begin
				mem_req = 1'b1;
				mem_addr = BSD_TRAP_VEC_BASE + {13'h0000, f_vec, 1'b0};
			end
			default: mem_req = 1'b0;
		endcase
	end

	// ============================================================
	// Operand helpers
	always_comb begin
		ea = 16'(bsd_ea_extend(f_long ? BSD_EXT_32 : BSD_EXT_16, ext_q));
		disp8 = 16'(bsd_ea_extend(BSD_EXT_8, {24'h000000, f_imm}));
		ctl_val = f_op2[3] ? exr_q : ccr_q;
		unique case (f_op2[2:0])
			BSD_CTL_AND: ctl_res = ctl_val & f_imm;
			BSD_CTL_OR: ctl_res = ctl_val | f_imm;
			BSD_CTL_XOR: ctl_res = ctl_val ^ f_imm;
			default: ctl_res = f_imm;
		endcase
		// Byte form only sees the low counter byte
		count_zero = move_word_q ? (count_q == 16'h0000) : (count_q[7:0] == 8'h00);
		count_dec = move_word_q ? count_q - 16'h0001 : {count_q[15:8], count_q[7:0] - 8'h01};
	end

	// ============================================================
	// Sequencer next state
	always_comb begin
		state_d = state_q;
		pc_d = pc_q;
		ir_d = ir_q;
		ext_d = ext_q;
		ext_more_d = ext_more_q;
		ccr_d = ccr_q;
		exr_d = exr_q;
		count_d = count_q;
		src_d = src_q;
		dst_d = dst_q;
		link_d = link_q;
		save_pc_d = save_pc_q;
		save_ccr_d = save_ccr_q;
		save_exr_d = save_exr_q;
		mv_byte_d = mv_byte_q;
		move_word_d = move_word_q;
		run_d = run_q;
		illegal_d = illegal_q;
		op2_d = op2_q;
		rn_d = rn_q;
		rd_d = rd_q;
		// Clear first, so a same-cycle set from the sequencer wins
		if (reg_wr && reg_addr == BSD_REG_STATUS && reg_wdata[9]) illegal_d = 1'b0;
		unique case (state_q)
			ST_HALT: if (run_q) state_d = ST_FETCH;
			ST_FETCH: begin
				if (!run_q) begin
					state_d = ST_HALT;
				end else if (mem_ack) begin
					ir_d = mem_rdata;
					pc_d = pc_q + BSD_PC_STEP;
					ext_d = 32'h0000_0000;
					ext_more_d = 1'b0;
					state_d = ST_EXEC;
				end
			end
			ST_EXT: if (mem_ack) begin
				ext_d = {ext_q[15:0], mem_rdata};
				pc_d = pc_q + BSD_PC_STEP;
				ext_more_d = 1'b1;
				if (!f_long || ext_more_q) state_d = ST_EXEC;
			end
			ST_EXEC: begin
				op2_d = f_op2;
				rn_d = f_rn;
				rd_d = f_rd;
				state_d = ST_FETCH;
				if (f_ext && !(ext_more_q)) begin
					state_d = ST_EXT;
					ext_more_d = 1'b0;
				end else begin
					unique case (f_op)
						BSD_OP_SYS: begin
							unique case (f_op2)
								BSD_SYS_NOP: state_d = ST_FETCH;
								BSD_SYS_SLEEP: state_d = ST_SLEEP;
								BSD_SYS_RTE: begin
									pc_d = save_pc_q;
									ccr_d = save_ccr_q;
									exr_d = save_exr_q;
								end
								BSD_SYS_TRAP: begin
									save_pc_d = pc_q;
									save_ccr_d = ccr_q;
									save_exr_d = exr_q;
									state_d = ST_VEC;
								end
								BSD_SYS_RTS: pc_d = link_q;
								default: begin
									illegal_d = 1'b1;
									state_d = ST_HALT;
									run_d = 1'b0;
								end
							endcase
						end
						BSD_OP_BCC: if (taken) pc_d = pc_q + disp8;
						BSD_OP_JUMP: begin
							// One-level link: nested calls need software to save it
							if (f_op2 != BSD_JMP_ABS) link_d = pc_q;
							pc_d = (f_op2 == BSD_JMP_BSR) ? pc_q + ea : ea;
						end
						BSD_OP_CTL: begin
							if (f_op2[2:0] == BSD_CTL_LDM || f_op2[2:0] == BSD_CTL_STM) begin
								state_d = ST_MEM;
							end else if (f_op2[3]) begin
								exr_d = ctl_res;
							end else begin
								ccr_d = ctl_res;
							end
						end
						BSD_OP_MOVE: begin
							move_word_d = f_op2[0];
							if (f_op2[0] ? (count_q != 16'h0000) : (count_q[7:0] != 8'h00)) state_d = ST_MV_RD;
						end
						default: begin
							illegal_d = 1'b1;
							state_d = ST_HALT;
							run_d = 1'b0;
						end
					endcase
				end
			end
			ST_MEM: if (mem_ack) begin
				state_d = ST_FETCH;
				if (f_op2[2:0] == BSD_CTL_LDM) begin
					if (f_op2[3]) exr_d = mem_rdata[15:8];
					else ccr_d = mem_rdata[15:8];
				end
			end
			ST_MV_RD: if (mem_ack) begin
				mv_byte_d = mem_rdata[7:0];
				src_d = src_q + 16'h0001;
				state_d = ST_MV_WR;
			end
			ST_MV_WR: if (mem_ack) begin
				dst_d = dst_q + 16'h0001;
				count_d = count_dec;
				// Stay in the move until the counter runs out
				state_d = (count_dec == 16'h0000 || (!move_word_q && count_dec[7:0] == 8'h00)) ?
					ST_FETCH : ST_MV_RD;
			end
			ST_VEC: if (mem_ack) begin
				pc_d = mem_rdata;
				state_d = ST_FETCH;
			end
			ST_SLEEP: if (wake_sync_q || !run_q) state_d = run_q ? ST_FETCH : ST_HALT;
			default: state_d = ST_HALT;
		endcase
		// Software writes other than the status clear win over the sequencer's own updates
		if (reg_wr) begin
			unique case (reg_addr)
				BSD_REG_CTRL: run_d = reg_wdata[0];
				BSD_REG_STATUS: illegal_d = illegal_d;
				BSD_REG_PC: pc_d = reg_wdata;
				BSD_REG_CCR: ccr_d = reg_wdata[7:0];
				BSD_REG_EXR: exr_d = reg_wdata[7:0];
				BSD_REG_COUNT: count_d = reg_wdata;
				BSD_REG_SRC: src_d = reg_wdata;
				BSD_REG_DST: dst_d = reg_wdata;
				default: run_d = run_d;
			endcase
		end
	end

	// ============================================================
	// Register read port
	always_comb begin
		rdata_d = 16'h0000;
		if (reg_rd) begin
			unique case (reg_addr)
				BSD_REG_CTRL: rdata_d = {15'h0000, run_q};
				BSD_REG_STATUS: rdata_d = {6'h00, illegal_q, state_q};
				BSD_REG_PC: rdata_d = pc_q;
				BSD_REG_CCR: rdata_d = {8'h00, ccr_q};
				BSD_REG_EXR: rdata_d = {8'h00, exr_q};
				BSD_REG_COUNT: rdata_d = count_q;
				BSD_REG_SRC: rdata_d = src_q;
				BSD_REG_DST: rdata_d = dst_q;
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		// Wake pin crosses in from outside
		wake_meta_q <= wake_pin;
		wake_sync_q <= wake_meta_q;
		if (!rstn) begin
			state_q <= ST_HALT;
			pc_q <= BSD_RESET_PC;
			ir_q <= 16'h0000;
			ext_q <= 32'h0000_0000;
			ext_more_q <= 1'b0;
			ccr_q <= BSD_CCR_RESET;
			exr_q <= BSD_EXR_RESET;
			count_q <= 16'h0000;
			src_q <= 16'h0000;
			dst_q <= 16'h0000;
			link_q <= 16'h0000;
			save_pc_q <= 16'h0000;
			save_ccr_q <= BSD_CCR_RESET;
			save_exr_q <= BSD_EXR_RESET;
			mv_byte_q <= 8'h00;
			move_word_q <= 1'b0;
			run_q <= 1'b0;
			illegal_q <= 1'b0;
			rdata_q <= 16'h0000;
			op2_q <= 4'h0;
			rn_q <= 3'h0;
			rd_q <= 4'h0;
		end else begin
			state_q <= state_d;
			pc_q <= pc_d;
			ir_q <= ir_d;
			ext_q <= ext_d;
			ext_more_q <= ext_more_d;
			ccr_q <= ccr_d;
			exr_q <= exr_d;
			count_q <= count_d;
			src_q <= src_d;
			dst_q <= dst_d;
			link_q <= link_d;
			save_pc_q <= save_pc_d;
			save_ccr_q <= save_ccr_d;
			save_exr_q <= save_exr_d;
			mv_byte_q <= mv_byte_d;
			move_word_q <= move_word_d;
			run_q <= run_d;
			illegal_q <= illegal_d;
			rdata_q <= rdata_d;
			op2_q <= op2_d;
			rn_q <= rn_d;
			rd_q <= rd_d;
		end
	end

	always_comb begin
		reg_rdata = rdata_q;
		sleeping = (state_q == ST_SLEEP);
		dec_op2 = op2_q;
		dec_rn = rn_q;
		dec_rd = rd_q;
	end
endmodule

//--- test/bsd_mem.sv
`timescale 1ns/1ps

// ============================================================
// Memory and fetch side, answer delay set by the bench
module bsd_mem (
	input wire logic clk_sys,
	input wire logic [1:0] lat,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic mem_word,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata,
	output logic mem_ack
);
	logic [7:0] mem [0:65535];
	logic [1:0] cnt = 2'h0;
	logic [15:0] hold = 16'h0000;
	logic [15:0] last_rd, wr_addr, wr_data;
	assign mem_ack = mem_req && cnt >= lat;
	// Idle data lines carry the inverse of the last answer, so a late sample shows up
	assign mem_rdata = !mem_ack ? ~hold : mem_word ? {mem[mem_addr], mem[mem_addr + 16'h0001]} : {8'h00, mem[mem_addr]};
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 8'hf0;
	end
	always @(posedge clk_sys) begin
		cnt <= (mem_req && !mem_ack) ? cnt + 2'h1 : 2'h0;
		if (mem_ack && !mem_we) begin
			hold <= mem_rdata;
			if (mem_word) last_rd <= mem_addr;
		end
		if (mem_ack && mem_we) begin
			wr_addr <= mem_addr;
			wr_data <= mem_wdata;
			mem[mem_addr] <= mem_word ? mem_wdata[15:8] : mem_wdata[7:0];
			if (mem_word) mem[mem_addr + 16'h0001] <= mem_wdata[7:0];
		end
	end
endmodule

//--- test/bsd_core_checker.sv
`timescale 1ns/1ps

// ============================================================
// Port checks for the core
module bsd_core_checker (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic reg_wr,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic mem_word,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic wake_pin,
	input wire logic sleeping
);
	logic seen_q, seen_d;
	logic [15:0] last_q, last_d;
	// Previous byte read of a move; any word read ends the walk
	always_comb begin
		seen_d = seen_q;
		last_d = last_q;
		if (mem_req && mem_ack && !mem_we) begin
			seen_d = !mem_word;
			last_d = mem_addr;
		end
	end
	always_ff @(posedge clk_sys) begin
		seen_q <= rstn && seen_d;
		last_q <= last_d;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_word))
		else $error("memory request changed before its answer");
	wdata_hold_a: assert property (mem_req && mem_we && !mem_ack |=> $stable(mem_wdata) && mem_we)
		else $error("write data changed before its answer");
	word_even_a: assert property (mem_req && mem_word |-> !mem_addr[0])
		else $error("word access at odd address");
	sleep_quiet_a: assert property (sleeping |-> !mem_req)
		else $error("memory request while asleep");
	sleep_stay_a: assert property ((sleeping && !wake_pin && !reg_wr) [*4] |=> sleeping)
		else $error("left sleep without wake");
	wake_exit_a: assert property (sleeping && wake_pin |-> ##[1:5] !sleeping)
		else $error("wake did not end sleep");
	store_word_a: assert property (mem_req && mem_we && mem_word |-> mem_wdata[7:0] == 8'h00)
		else $error("control store data not in upper byte");
	byte_wr_a: assert property (mem_req && mem_we && !mem_word |-> mem_wdata[15:8] == 8'h00)
		else $error("byte write with upper data set");
	rd_then_wr_a: assert property (mem_req && mem_ack && !mem_we && !mem_word |=> ##[0:2] (mem_req && mem_we && !mem_word))
		else $error("byte read not followed by byte write");
	post_inc_a: assert property (mem_req && !mem_we && !mem_word && seen_q |-> mem_addr == last_q + 16'h0001)
		else $error("source pointer did not step by one");
	cover property (sleeping);
	cover property (mem_req && mem_ack && mem_we && mem_word);
	cover property (mem_req && mem_ack && mem_we && !mem_word);
endmodule

bind bsd_core bsd_core_checker u_bsd_core_checker (.clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr),
	.mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
	.mem_ack(mem_ack), .wake_pin(wake_pin), .sleeping(sleeping));

//--- test/bsd_core_tb.sv
`timescale 1ns/1ps

module bsd_core_tb import bsd_pkg::*; ;
	logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, wake_pin = 1'b0, rd_p = 1'b0;
	logic [7:0] reg_addr = 8'h00, f, m;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, mem_addr, mem_wdata, mem_rdata, rd_val, e;
	logic [1:0] lat = 2'h0;
	logic mem_req, mem_we, mem_word, mem_ack, sleeping;
	logic [3:0] d_op2, d_rd;
	logic [2:0] d_rn;
	logic [15:0] eq[$];
	logic mq[$];
	int err_total = 0, comparisons = 0, cyc = 0, seed = 73, r;
	always #20 clk_sys = ~clk_sys;
	bsd_core u_bsd_core (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .wake_pin(wake_pin),
		.sleeping(sleeping), .dec_op2(d_op2), .dec_rn(d_rn), .dec_rd(d_rd));
	bsd_mem u_bsd_mem (.clk_sys(clk_sys), .lat(lat), .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	// ============================================================
	// Checking and bus tasks
	task automatic test_done();
		if (err_total == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] x, input logic [15:0] g);
		comparisons++;
		if (g !== x) begin
			err_total++;
			$display("wrong value at %0t: expected %h got %h", $time, x, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] x, input logic k);
		eq.push_back(x);
		mq.push_back(k);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask
	task automatic ld(input logic [15:0] a, input logic [15:0] w);
		u_bsd_mem.mem[a] = w[15:8];
		u_bsd_mem.mem[a + 16'h0001] = w[7:0];
	endtask
	task automatic rnd();
		r = $random(seed);
		f = r[7:0];
		m = r[15:8];
	endtask
	// Polls the one-hot state until the core stops on the illegal filler word
	task automatic wait_halt();
		for (int n = 0; n < 1500; n++) begin
			rd(BSD_REG_STATUS, 16'h0000, 1'b0);
			@(posedge clk_sys);
			#1;
			if (rd_val[0] === 1'b1) break;
		end
	endtask
	task automatic run();
		r = $random(seed);
		lat <= r[1:0];
		wr(BSD_REG_PC, 16'h0200);
		wr(BSD_REG_CTRL, 16'h0001);
		wait_halt();
	endtask
	task automatic mv(input logic [15:0] cnt, input logic [15:0] op, input int n, input logic [15:0] left);
		wr(BSD_REG_COUNT, cnt);
		wr(BSD_REG_SRC, 16'h0500);
		wr(BSD_REG_DST, 16'h0800);
		ld(16'h0200, op);
		for (int j = 0; j < 300; j++) begin
			r = $random(seed);
			u_bsd_mem.mem[16'h0500 + j] = r[7:0];
			u_bsd_mem.mem[16'h0800 + j] = 8'hf0;
		end
		run();
		for (int j = 0; j <= n; j++) begin
			chk({8'h00, j < n ? u_bsd_mem.mem[16'h0500 + j] : 8'hf0}, {8'h00, u_bsd_mem.mem[16'h0800 + j]});
		end
		rd(BSD_REG_SRC, 16'h0500 + 16'(n), 1'b1);
		rd(BSD_REG_DST, 16'h0800 + 16'(n), 1'b1);
		rd(BSD_REG_COUNT, left, 1'b1);
		chk(16'h0202, u_bsd_mem.last_rd);
	endtask
	function automatic logic cond(input logic [3:0] c, input logic [7:0] g);
		logic t;
		case (c[3:1])
			3'h0: t = 1'b1;
			3'h1: t = !(g[0] || g[2]);
			3'h2: t = !g[0];
			3'h3: t = !g[2];
			3'h4: t = !g[1];
			3'h5: t = !g[3];
			3'h6: t = !(g[3] ^ g[1]);
			default: t = !(g[2] || (g[3] ^ g[1]));
		endcase
		return t ^ c[0];
	endfunction
	// ============================================================
	// Result watcher and hang guard
	always @(posedge clk_sys) begin
		if (rd_p) begin
			rd_val = reg_rdata;
			e = eq.pop_front();
			if (mq.pop_front()) chk(e, reg_rdata);
		end
		rd_p <= reg_rd;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			test_done();
		end
	end
	// ============================================================
	// Scenarios
	initial begin
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(BSD_REG_PC, BSD_RESET_PC, 1'b1);
		rd(BSD_REG_CCR, {8'h00, BSD_CCR_RESET}, 1'b1);
		rd(BSD_REG_EXR, {8'h00, BSD_EXR_RESET}, 1'b1);
		wr(8'h24, 16'hffff);
		rd(8'h24, 16'h0000, 1'b1);
		for (int i = 0; i < 48; i++) begin
			rnd();
			wr(BSD_REG_CCR, {8'h00, f});
			ld(16'h0200, {4'h4, 4'(i), m[7:3], 3'b100});
			run();
			chk(cond(4'(i), f) ? 16'h0202 + {{8{m[7]}}, m[7:3], 3'b100} : 16'h0202, u_bsd_mem.last_rd);
			rd(BSD_REG_CCR, {8'h00, f}, 1'b1);
		end
		rnd();
		wr(BSD_REG_CCR, {8'h00, f});
		ld(16'h0200, 16'h0000);
		run();
		chk(16'h0202, u_bsd_mem.last_rd);
		rd(BSD_REG_CCR, {8'h00, f}, 1'b1);
		for (int k = 0; k < 6; k++) begin
			rnd();
			wr(k < 3 ? BSD_REG_CCR : BSD_REG_EXR, {8'h00, f});
			ld(16'h0200, {4'h1, k >= 3, 3'(k % 3), m});
			run();
			e = {8'h00, (k % 3 == 0) ? (f & m) : (k % 3 == 1) ? (f | m) : (f ^ m)};
			rd(k < 3 ? BSD_REG_CCR : BSD_REG_EXR, e, 1'b1);
		end
		ld(16'h0300, 16'h11ff);
		ld(16'h0302, 16'h0200);
		for (int v = 0; v < 4; v++) begin
			for (int k = 0; k < 4; k++) ld(BSD_TRAP_VEC_BASE + 16'(2 * k), k == v ? 16'h0300 : 16'hf0f0);
			ld(16'h0200, {10'h00c, 2'(v), 4'h0});
			rnd();
			wr(BSD_REG_CCR, {8'h00, f});
			run();
			chk(16'h0202, u_bsd_mem.last_rd);
			rd(BSD_REG_CCR, {8'h00, f}, 1'b1);
		end
		mv(16'h0103, 16'h7000, 3, 16'h0100);
		mv(16'h0100, 16'h7000, 0, 16'h0100);
		mv(16'h0000, 16'h7100, 0, 16'h0000);
		mv(16'h0102, 16'h7100, 258, 16'h0000);
		rnd();
		ld(16'h0200, {8'h01, m});
		wr(BSD_REG_PC, 16'h0200);
		wr(BSD_REG_CTRL, 16'h0001);
		for (int n = 0; n < 50 && sleeping !== 1'b1; n++) @(posedge clk_sys);
		repeat (20) @(posedge clk_sys);
		chk(16'h0001, {15'h0000, sleeping});
		chk(16'h0200, u_bsd_mem.last_rd);
		chk(16'h0001, {12'h000, d_op2});
		chk({13'h0000, m[6:4]}, {13'h0000, d_rn});
		chk({12'h000, m[3] ? {1'b0, m[2:0]} : m[7:4]}, {12'h000, d_rd});
		wake_pin <= 1'b1;
		for (int n = 0; n < 50 && sleeping !== 1'b0; n++) @(posedge clk_sys);
		wake_pin <= 1'b0;
		wait_halt();
		chk(16'h0202, u_bsd_mem.last_rd);
		ld(16'h0200, 16'h5000);
		ld(16'h0202, 16'h0340);
		run();
		chk(16'h0340, u_bsd_mem.last_rd);
		ld(16'h0200, 16'h5100);
		ld(16'h0202, 16'h0350);
		ld(16'h0350, 16'h0400);
		run();
		chk(16'h0204, u_bsd_mem.last_rd);
		rnd();
		wr(BSD_REG_CCR, {8'h00, f});
		ld(16'h0200, 16'h1500);
		ld(16'h0202, 16'h0400);
		run();
		chk(16'h0400, u_bsd_mem.wr_addr);
		chk({f, 8'h00}, u_bsd_mem.wr_data);
		ld(16'h0200, 16'h1c00);
		ld(16'h0202, 16'h0402);
		ld(16'h0402, {m, f});
		run();
		rd(BSD_REG_EXR, {8'h00, m}, 1'b1);
		repeat (3) @(posedge clk_sys);
		test_done();
	end
endmodule
